// file: bench/tcl_conv_model.sv
`timescale 1ns/1ns
module tcl_conv_model
(
    // Clock and request
    input wire logic core_clk,
    input wire logic conv_req,
    input wire logic [7:0] conv_value,
    // Converter outputs
    output logic [7:0] temp_raw,
    output logic temp_valid
);
    initial temp_raw = 8'h5A;
    initial temp_valid = 1'b0;
    // Churn outside the pulse so a stale index never looks valid
    always @(posedge core_clk)
    begin
        temp_valid <= conv_req;
        temp_raw <= conv_req ? conv_value : ~temp_raw + 8'h01;
    end
endmodule

// file: bench/tcl_loader_asserts.sv
`timescale 1ns/1ns
module tcl_loader_asserts
    import tcl_pkg::*;
(
    // Clock, reset, bus
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic unlock_override,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Calibration outputs
    input wire logic [15:0] setup_word,
    input wire logic [15:0] offset_drift_coeff_reg,
    input wire logic [15:0] span_drift_coeff_reg,
    input wire logic [3:0] coarse_gain,
    input wire logic res_select_internal
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic wr_acc;
    assign wr_acc = psel & penable & pwrite;
    a_gain_field: assert property (coarse_gain == setup_word[3:0])
        else $error("gain field wrong");
    a_res_field: assert property (res_select_internal == setup_word[4])
        else $error("resistor select wrong");
    a_ready_high: assert property (psel && penable |-> pready) else $error("no ready");
    a_read_no_err: assert property (psel && penable && !pwrite |-> !pslverr)
        else $error("read refused");
    a_override_ok: assert property (wr_acc && unlock_override |-> !pslverr)
        else $error("override write refused");
    a_err_on_write: assert property (pslverr |-> wr_acc) else $error("stray error");
    a_ofs_drift_wr: assert property (wr_acc && !pslverr && paddr == 32'h0000000C
        |=> offset_drift_coeff_reg == $past(pwdata[15:0])) else $error("drift write lost");
    a_span_drift_wr: assert property (wr_acc && !pslverr && paddr == 32'h00000010
        |=> span_drift_coeff_reg == $past(pwdata[15:0])) else $error("span write lost");
endmodule
bind tcl_loader tcl_loader_asserts tcl_loader_asserts_inst (.core_clk, .reset_n,
    .unlock_override, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .setup_word, .offset_drift_coeff_reg, .span_drift_coeff_reg, .coarse_gain,
    .res_select_internal);

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import tcl_pkg::*;
    logic core_clk, reset_n, unlock_override, psel, penable, pwrite, pready, pslverr;
    logic temp_valid, res_select_internal, conv_req, err;
    logic [7:0] temp_raw, conv_value;
    logic [31:0] paddr, pwdata, prdata, rd, lfsr_q;
    logic [15:0] setup_word, offset_trim_reg, span_trim_reg;
    logic [15:0] offset_drift_coeff_reg, span_drift_coeff_reg;
    logic [3:0] coarse_gain;
    int err_total = 0;
    int n_tests = 0;
    int mem [768];
    tcl_loader tcl_loader_inst (.core_clk, .reset_n, .temp_raw, .temp_valid,
        .unlock_override, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .setup_word, .offset_trim_reg, .span_trim_reg, .offset_drift_coeff_reg,
        .span_drift_coeff_reg, .coarse_gain, .res_select_internal);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    tcl_conv_model tcl_conv_model_inst (.core_clk, .conv_req, .conv_value, .temp_raw,
        .temp_valid);
    function automatic int wd(input int a);
        return mem[a] + 256 * mem[a + 1];
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_regs(input int idx);
        int i;
        i = (idx > 'hAF) ? 'hAF : idx;
        cmp(setup_word, wd('h160));
        cmp(coarse_gain, wd('h160) & 'hF);
        cmp(res_select_internal, (wd('h160) >> 4) & 1);
        cmp(offset_drift_coeff_reg, wd('h164));
        cmp(span_drift_coeff_reg, wd('h168));
        cmp(offset_trim_reg, wd(2 * i));
        cmp(span_trim_reg, wd(i < 128 ? 'h200 + 2 * i : 'h1A0 + 2 * (i - 128)));
    endtask
    task automatic complete_run;
        $display("Checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        #(50 * 90000);
        err_total++;
        complete_run();
    end
    initial
    begin
        {reset_n, psel, penable, pwrite, unlock_override, conv_req} = 6'h00;
        {paddr, pwdata, conv_value} = 72'h0;
        lfsr_q = 32'h3FFD;
        for (int a = 0; a < 768; a++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            mem[a] = (a == 'h16A || a == 'h15E || a == 'h15F) ? 'hFF : lfsr_q[7:0];
            mem[a] = (a == 'h1A0 || a == 'h1A1) ? 0 : mem[a];
            tcl_loader_inst.nv_mem[a] = mem[a][7:0];
        end
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        check_regs(0);
        foreach (mem[v])
        begin
            if (v == 'h80 || v == 'hAF || v == 'hFF)
            begin
                conv_req <= 1'b1;
                conv_value <= v[7:0];
                @(posedge core_clk);
                conv_req <= 1'b0;
                repeat (20020) @(posedge core_clk);
                check_regs(v);
            end
        end
        // Locked: writes bounce and leave the word alone
        apb(1'b1, REG_OFS_DRIFT, lfsr_q);
        cmp(err, 1);
        cmp(offset_drift_coeff_reg, wd('h164));
        unlock_override <= 1'b1;
        apb(1'b1, REG_OFS_DRIFT, lfsr_q);
        cmp(err, 0);
        apb(1'b1, REG_SPAN_DRIFT, 32'h0000FFFF);
        apb(1'b1, REG_SETUP, 32'h0000001B);
        apb(0, REG_OFS_DRIFT, 0);
        cmp(rd, {16'h0, lfsr_q[15:0]});
        apb(0, REG_SPAN_DRIFT, 0);
        cmp(rd, 32'h0000FFFF);
        cmp(coarse_gain, 32'hB);
        cmp(res_select_internal, 1);
        apb(0, 8'h40, 0);
        cmp(rd, 0);
        // Host rewrites the setup word in the array; a fresh reset reloads it
        for (int b = 0; b < 2; b++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            mem['h160 + b] = lfsr_q[7:0];
            apb(1'b1, NV_WRITE_BASE + 4 * ('h160 + b), lfsr_q);
            cmp(err, 0);
        end
        unlock_override <= 1'b0;
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        check_regs(0);
        apb(0, REG_STATUS, 0);
        cmp(rd, {14'h0, 8'h00, 8'hFF, 2'b00});
        complete_run();
    end
endmodule

// file: logic/tcl_loader.sv
`timescale 1ns/1ns
// How it works
// - Five 16-bit calibration registers, loaded from memory or over the bus.
// - Internal 768-byte array holds setup, tables and drift words.
// - 52 user bytes are stored but never interpreted.
// - Offset trim comes from a 176-entry 16-bit temperature table.
// - Every millisecond the offset entry at current index is transferred.
// - Index never below 00h; colder selects entry zero.
// - Index saturates at AFh; no wraparound.
// - Span trim from second 176-entry table, clamped the same way.
// - Coarse gain is one of 16 settings in the setup word.
// - Setup bit selects internal or external feedback resistors.
// - Trim and drift codes span full 0000h to FFFFh.
// - Offset and span drift registers hold 16-bit host-written coefficients.
// - Auto-load only when lock byte FFh, override low, after reset.
// - Locked power-up loads fixed words and indexed table words.
// - Each 1 ms period, all five registers reload.
// - Converter supplies an 8-bit temperature index each millisecond.
// - Each word assembles from adjacent low and high bytes.
// - Offset table 000h-15Fh; span table 200h-2FFh then 1A0h-1FFh.
// - Bus writes allowed only if lock byte 00h or override high.
module tcl_loader
    import tcl_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Temperature converter
    input wire logic [7:0] temp_raw,
    input wire logic temp_valid,
    input wire logic unlock_override,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Calibration outputs
    output logic [15:0] setup_word,
    output logic [15:0] offset_trim_reg,
    output logic [15:0] span_trim_reg,
    output logic [15:0] offset_drift_coeff_reg,
    output logic [15:0] span_drift_coeff_reg,
    output logic [3:0] coarse_gain,
    output logic res_select_internal
);
    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_FETCH_LO, ST_FETCH_HI, ST_NEXT} tcl_state_type;

    logic [7:0] nv_mem [0:NV_BYTES-1];
    tcl_state_type state_q, state_d;
    logic [2:0] item_q, item_d;
    logic [7:0] lo_q, lo_d;
    logic [7:0] index_q, index_d;
    logic [7:0] lock_q, lock_d;
    logic [15:0] regs_q [0:4];
    logic [15:0] regs_d [0:4];
    logic [31:0] timer_q, timer_d;
    // Millisecond enable, load start and frozen fetch index
    logic reload_tick;
    logic load_start;
    logic [7:0] snap_q, snap_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] rd_byte;
    logic [9:0] fetch_addr;
    logic [9:0] base_addr;
    logic locked;
    logic open_access;
    logic acc;
    logic [9:0] nv_waddr;
    logic nv_we;

    // Clamp the raw index
    logic [7:0] index_clamped;
    always_comb
    begin
        if (temp_raw > INDEX_MAX)
            index_clamped = INDEX_MAX;
        else
            index_clamped = temp_raw;
    end

    assign locked = (lock_q == LOCK_SET) && !unlock_override;
    assign open_access = (lock_q == LOCK_OPEN) || unlock_override;
    assign acc = psel && penable;

    // A load starts at boot when locked, then on every tick while locked
    assign load_start = (state_q == ST_BOOT && rd_byte == LOCK_SET && !unlock_override)
        || (state_q == ST_IDLE && locked && reload_tick);

    // Millisecond divider gives a one-cycle enable
    // An enable rather than a slow clock keeps the whole block in one domain
    always_comb
    begin
        reload_tick = (timer_q == RELOAD_CYCLES - 1);
        if (reload_tick)
            timer_d = '0;
        else
            timer_d = timer_q + 32'd1;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            timer_q <= '0;
        else
            timer_q <= timer_d;
    end

    // Temperature index; the snapshot taken at load start keeps both bytes
    // of a table word from straddling two entries
    always_comb
    begin
        index_d = index_q;
        snap_d = snap_q;
        if (temp_valid)
            index_d = index_clamped;
        if (load_start)
            snap_d = index_q;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            index_q <= INDEX_MIN;
            snap_q <= INDEX_MIN;
        end
        else
        begin
            index_q <= index_d;
            snap_q <= snap_d;
        end
    end

    // Word base per item: 0 setup, 1 offset trim, 2 span trim, 3/4 drifts
    always_comb
    begin
        case (item_q)
            3'd0: base_addr = SETUP_ADDR;
            // Table words use the frozen index snapshot
            3'd1: base_addr = OFS_TABLE_BASE + {1'b0, snap_q, 1'b0};
            3'd2:
            begin
                if (snap_q < SPAN_SPLIT_INDEX)
                    base_addr = SPAN_TABLE_LO_BASE + {1'b0, snap_q, 1'b0};
                else
                    base_addr = SPAN_TABLE_HI_BASE
                        + {1'b0, snap_q - SPAN_SPLIT_INDEX, 1'b0};
            end
            3'd3: base_addr = OFS_DRIFT_ADDR;
            3'd4: base_addr = SPAN_DRIFT_ADDR;
            default: base_addr = LOCK_ADDR;
        endcase
    end

    assign fetch_addr = (state_q == ST_FETCH_HI) ? base_addr + 10'h001 : base_addr;
    assign rd_byte = nv_mem[state_q == ST_BOOT ? LOCK_ADDR : fetch_addr];

    // Array write path, host only when open
    assign nv_waddr = paddr[11:2] - NV_WRITE_BASE[11:2];
    assign nv_we = acc && pwrite && open_access
        && paddr >= NV_WRITE_BASE && paddr < NV_WRITE_END;

    always_ff @(posedge core_clk)
    begin
        if (nv_we)
            nv_mem[nv_waddr] <= pwdata[7:0];
    end

    // Loader sequence
    always_comb
    begin
        state_d = state_q;
        item_d = item_q;
        lo_d = lo_q;
        lock_d = lock_q;
        for (int i = 0; i < 5; i++)
            regs_d[i] = regs_q[i];
        case (state_q)
            ST_BOOT:
            begin
                lock_d = rd_byte;
                if (load_start)
                begin
                    item_d = '0;
                    state_d = ST_FETCH_LO;
                end
                else
                    state_d = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (load_start)
                begin
                    item_d = '0;
                    state_d = ST_FETCH_LO;
                end
            end
            ST_FETCH_LO:
            begin
                lo_d = rd_byte;
                state_d = ST_FETCH_HI;
            end
            ST_FETCH_HI:
            begin
                regs_d[item_q] = {rd_byte, lo_q};
                state_d = ST_NEXT;
            end
            ST_NEXT:
            begin
                if (item_q == 3'd4)
                    state_d = ST_IDLE;
                else
                begin
                    item_d = item_q + 3'd1;
                    state_d = ST_FETCH_LO;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Direct loading over the bus when open
        if (acc && pwrite && open_access && paddr < {24'h0, REG_STATUS}
            && paddr[1:0] == 2'b00)
            regs_d[paddr[4:2]] = pwdata[15:0];
    end

    // Bus read data
    always_comb
    begin
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                {24'h0, REG_SETUP}: prdata_d = {16'h0, regs_q[0]};
                {24'h0, REG_OFS_TRIM}: prdata_d = {16'h0, regs_q[1]};
                {24'h0, REG_SPAN_TRIM}: prdata_d = {16'h0, regs_q[2]};
                {24'h0, REG_OFS_DRIFT}: prdata_d = {16'h0, regs_q[3]};
                {24'h0, REG_SPAN_DRIFT}: prdata_d = {16'h0, regs_q[4]};
                {24'h0, REG_STATUS}: prdata_d = {14'h0, index_q, lock_q,
                    state_q != ST_IDLE, open_access};
                default: prdata_d = 32'h0;
            endcase
        end
    end

    // Loader state; lock reads open until the array byte is seen
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_BOOT;
            item_q <= '0;
            lo_q <= '0;
            lock_q <= LOCK_OPEN;
        end
        else
        begin
            state_q <= state_d;
            item_q <= item_d;
            lo_q <= lo_d;
            lock_q <= lock_d;
        end
    end

    // One flop bank per calibration word
    for (genvar g = 0; g < 5; g++)
    begin : gen_word
        always_ff @(posedge core_clk or negedge reset_n)
        begin
            if (!reset_n)
                regs_q[g] <= '0;
            else
                regs_q[g] <= regs_d[g];
        end
    end

    // Read data captured in setup, stands through access
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            prdata_q <= '0;
        else
            prdata_q <= prdata_d;
    end

    // Zero-wait slave; locked writes fail visibly
    assign pready = 1'b1;
    assign pslverr = acc && pwrite && !open_access;
    assign prdata = prdata_q;

    assign setup_word = regs_q[0];
    assign offset_trim_reg = regs_q[1];
    assign span_trim_reg = regs_q[2];
    assign offset_drift_coeff_reg = regs_q[3];
    assign span_drift_coeff_reg = regs_q[4];
    assign coarse_gain = regs_q[0][GAIN_LSB +: GAIN_W];
    assign res_select_internal = regs_q[0][RES_SEL_BIT];
endmodule

// file: logic/tcl_pkg.sv
package tcl_pkg;
    // Nonvolatile array geometry
    localparam int unsigned NV_BYTES = 768;
    localparam int unsigned NV_ADDR_W = 10;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned TABLE_ENTRIES = 176;
    localparam int unsigned USER_BYTES = 52;
    // Fixed word locations (low byte address)
    localparam logic [9:0] SETUP_ADDR = 10'h160;
    localparam logic [9:0] OFS_DRIFT_ADDR = 10'h164;
    localparam logic [9:0] SPAN_DRIFT_ADDR = 10'h168;
    localparam logic [9:0] LOCK_ADDR = 10'h16A;
    localparam logic [9:0] USER_BASE_ADDR = 10'h16C;
    // Table layout
    localparam logic [9:0] OFS_TABLE_BASE = 10'h000;
    localparam logic [9:0] SPAN_TABLE_LO_BASE = 10'h200;
    localparam logic [9:0] SPAN_TABLE_HI_BASE = 10'h1A0;
    localparam logic [7:0] SPAN_SPLIT_INDEX = 8'h80;
    localparam logic [7:0] INDEX_MIN = 8'h00;
    localparam logic [7:0] INDEX_MAX = 8'hAF;
    // Lock byte codes
    localparam logic [7:0] LOCK_SET = 8'hFF;
    localparam logic [7:0] LOCK_OPEN = 8'h00;
    // Setup word fields
    localparam int unsigned GAIN_LSB = 0;
    localparam int unsigned GAIN_W = 4;
    localparam int unsigned RES_SEL_BIT = 4;
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned RELOAD_PERIOD_US = 1000;
    localparam int unsigned RELOAD_CYCLES = CLK_HZ / 1_000_000 * RELOAD_PERIOD_US;
    // APB map
    localparam logic [7:0] REG_SETUP = 8'h00;
    localparam logic [7:0] REG_OFS_TRIM = 8'h04;
    localparam logic [7:0] REG_SPAN_TRIM = 8'h08;
    localparam logic [7:0] REG_OFS_DRIFT = 8'h0C;
    localparam logic [7:0] REG_SPAN_DRIFT = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [31:0] NV_WRITE_BASE = 32'h0000_1000;
    localparam logic [31:0] NV_WRITE_END = 32'h0000_1C00;
    typedef enum logic [1:0] {SLOT_LO, SLOT_HI} tcl_slot_type;
endpackage
